// >>> design/serial_port_defines.svh
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH
// register byte addresses
`define FMT_CTRL_OFS   32'h40040000
`define MODE_CTRL_OFS  32'h40040004
`define FIFO_DATA_OFS  32'h40040008
`define STATUS_OFS     32'h4004000c
`define PRESCALE_OFS   32'h40040010
// frame format control fields
`define WLEN_LSB       0
`define WLEN_MSB       3
`define FMT_LSB        4
`define FMT_MSB        5
`define CLOCK_IDLE_POLARITY_BIT       6
`define CLOCK_CAPTURE_PHASE_BIT       7
`define RATE_LSB       8
`define RATE_MSB       15
// mode control fields
`define LOOP_BIT       0
`define EN_BIT         1
`define ROLE_BIT       2
`define INHIB_BIT      3
// status fields
`define ST_TX_EMPTY    0
`define ST_TX_ROOM     1
`define ST_RX_ENTRY    2
`define ST_RX_FULL     3
`define ST_BUSY        4
// reset values
`define FMT_CTRL_RST   16'h0000
`define MODE_CTRL_RST  4'h0
`define PRESCALE_RST   8'h00
// smallest half-bit step in prescaler units
`define MIN_HALF_STEP  7'h01
`endif

// >>> design/serial_port_pkg.sv
// types shared by the serial port design
package serial_port_pkg;
   typedef enum logic [1:0] {FMT_SPI = 2'h0, FMT_SYNC_PULSE = 2'h1, FMT_HALF_DUPLEX = 2'h2,
                             FMT_UNUSED = 2'h3} frame_format_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} engine_state_t;
endpackage

// >>> design/word_fifo.sv
// flip-flop word fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [PW:0]      count_r, count_nxt;
   logic             push, pop;

   ////////////////////////////////////////////////////////////////////////////////
   // honest flags straight from the entry count
   assign in_ready  = (count_r != (PW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem_r[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // pointer and storage update
   always_comb
   begin
      mem_nxt    = mem_r;
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt  = count_r;
      if (push)
      begin
         mem_nxt[wr_ptr_r] = in_data;
         wr_ptr_nxt        = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
      end
      if (pop)
         rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
      if (push && !pop)
         count_nxt = count_r + (PW+1)'(1);
      else if (pop && !push)
         count_nxt = count_r - (PW+1)'(1);
   end

   // registers
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_r[i] <= '0;
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         mem_r    <= mem_nxt;
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
      end
   end
endmodule

// >>> design/serial_port_ctrl.sv
// synchronous serial port: registers, fifos and the shift engine
// Overview of operation
// - format codes 0,1,2 select frame variant
// - spi idle clock level follows polarity bit
// - phase 0 samples on leaving edge
// - phase 1 samples on returning edge
// - bit rate is clock over divisor times rate+1
// - loopback feeds own output into receiver
// - enable bit gates all bus activity
// - role changes only while port disabled
// - master drives clock, mosi, select
// - slave drives miso, receives the rest
// - inhibit bit stops slave driving miso
// - idle master starts new word at once
// - data read pops oldest received frame
// - short frames read right-aligned, upper zeros
// - frame length is word length code plus one
// - prescale divisor even, low bit reads zero
// - room flag low only while transmit full
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "serial_port_defines.svh"
module serial_port_ctrl import serial_port_pkg::*; #(
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // register port
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic [31:0]      rdata,
   // serial clock pin
   input  wire logic        sclk_in,
   output logic             sclk_out,
   output logic             sclk_oe,
   // master-out pin
   input  wire logic        mosi_in,
   output logic             mosi_out,
   output logic             mosi_oe,
   // master-in pin
   input  wire logic        miso_in,
   output logic             miso_out,
   output logic             miso_oe,
   // select pin
   input  wire logic        ssel_in,
   output logic             ssel_out,
   output logic             ssel_oe
);
   logic [15:0] fmt_r, fmt_nxt;
   logic [3:0]  mode_r, mode_nxt;
   logic [7:0]  pre_r, pre_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [3:0]  sync1_r, sync2_r;
   engine_state_t st_r, st_nxt;
   logic [6:0]  half_cnt_r, half_cnt_nxt;
   logic [7:0]  rate_cnt_r, rate_cnt_nxt;
   logic [5:0]  edge_cnt_r, edge_cnt_nxt;
   logic [4:0]  bit_cnt_r, bit_cnt_nxt;
   logic [15:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt;
   logic        sclk_r, sclk_nxt, ssel_r, ssel_nxt, sclk_d_r;
   logic        tx_push, tx_room, tx_valid, tx_pop, rx_valid, rx_room, rx_pop, rx_push;
   logic [15:0] tx_head, rx_head, rx_word, len_mask;
   logic [4:0]  len;
   logic [6:0]  half_step;
   logic        en, role, loop, inhib, clock_idle_polarity, clock_capture_phase, is_spi, idle_lvl, eff_clock_capture_phase;
   logic        sclk_s, mosi_s, miso_s, selected, out_bit, rx_in;
   logic        pre_tick, tog_tick, edge_evt, leave, sample, shift;
   frame_format_t ffmt;

   ////////////////////////////////////////////////////////////////////////////////
   // configuration decode
   assign ffmt     = frame_format_t'(fmt_r[`FMT_MSB:`FMT_LSB]);
   assign is_spi   = (ffmt == FMT_SPI);
   assign clock_idle_polarity     = fmt_r[`CLOCK_IDLE_POLARITY_BIT];
   assign clock_capture_phase     = fmt_r[`CLOCK_CAPTURE_PHASE_BIT];
   assign idle_lvl = is_spi & clock_idle_polarity;
   // the pulse-framed variant captures on the falling edge, the other non-spi codes like phase 0
   assign eff_clock_capture_phase = is_spi ? clock_capture_phase : (ffmt == FMT_SYNC_PULSE);
   assign len      = {1'b0, fmt_r[`WLEN_MSB:`WLEN_LSB]} + 5'h01;
   assign len_mask = ~(16'hffff << len);
   assign loop     = mode_r[`LOOP_BIT];
   assign en       = mode_r[`EN_BIT];
   assign role     = mode_r[`ROLE_BIT];
   assign inhib    = mode_r[`INHIB_BIT];
   // divisor below two would stall the engine, so it behaves as two
   assign half_step = (pre_r[7:1] == 7'h00) ? `MIN_HALF_STEP : pre_r[7:1];

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: sclk, mosi, miso, ssel
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync1_r  <= 4'hf;
         sync2_r  <= 4'hf;
         sclk_d_r <= 1'b1;                                             // matches sync reset, no false edge
      end
      else
      begin
         sync1_r  <= {ssel_in, miso_in, mosi_in, sclk_in};
         sync2_r  <= sync1_r;
         sclk_d_r <= sync2_r[0];
      end
   end
   assign sclk_s   = sync2_r[0];
   assign mosi_s   = sync2_r[1];
   assign miso_s   = sync2_r[2];
   assign selected = ~sync2_r[3];

   ////////////////////////////////////////////////////////////////////////////////
   // fifos
   word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .clock     (clock),
      .rst_b     (rst_b),
      .in_valid  (tx_push),
      .in_ready  (tx_room),
      .in_data   (wdata[15:0]),
      .out_valid (tx_valid),
      .out_ready (tx_pop),
      .out_data  (tx_head)
   );
   word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) rx_fifo (
      .clock     (clock),
      .rst_b     (rst_b),
      .in_valid  (rx_push),
      .in_ready  (rx_room),
      .in_data   (rx_word),
      .out_valid (rx_valid),
      .out_ready (rx_pop),
      .out_data  (rx_head)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // edge events shared by both roles
   assign pre_tick = (half_cnt_r == 7'h00);
   assign tog_tick = pre_tick && (rate_cnt_r == fmt_r[`RATE_MSB:`RATE_LSB]);
   assign edge_evt = (st_r == ST_SHIFT) &&
                     (role ? (selected && sclk_s != sclk_d_r) : tog_tick);
   // level after the edge differs from idle: the edge leaves the idle state
   assign leave    = role ? (sclk_s != idle_lvl) : (sclk_r == idle_lvl);
   assign sample   = edge_evt && (leave ^ eff_clock_capture_phase);
   assign shift    = edge_evt && !(leave ^ eff_clock_capture_phase) && (bit_cnt_r != 5'h00);
   assign out_bit  = tx_sh_r[fmt_r[`WLEN_MSB:`WLEN_LSB]];
   assign rx_in    = loop ? out_bit : (role ? mosi_s : miso_s);
   assign rx_word  = {rx_sh_r[14:0], rx_in} & len_mask;
   assign rx_push  = sample && (bit_cnt_r + 5'h01 == len);

   // shift engine next state
   always_comb
   begin
      st_nxt       = st_r;
      half_cnt_nxt = pre_tick ? half_step - 7'h01 : half_cnt_r - 7'h01;
      rate_cnt_nxt = rate_cnt_r;
      edge_cnt_nxt = edge_cnt_r;
      bit_cnt_nxt  = bit_cnt_r;
      tx_sh_nxt    = tx_sh_r;
      rx_sh_nxt    = rx_sh_r;
      sclk_nxt     = sclk_r;
      ssel_nxt     = ssel_r;
      tx_pop       = 1'b0;
      if (pre_tick)
         rate_cnt_nxt = tog_tick ? 8'h00 : rate_cnt_r + 8'h01;
      if (sample)
         rx_sh_nxt = {rx_sh_r[14:0], rx_in};
      if (shift)
         tx_sh_nxt = {tx_sh_r[14:0], 1'b0};
      if (sample)
         bit_cnt_nxt = bit_cnt_r + 5'h01;
      case (st_r)
         ST_IDLE:
         begin
            sclk_nxt     = idle_lvl;
            ssel_nxt     = (ffmt == FMT_SYNC_PULSE) ? 1'b0 : 1'b1;
            edge_cnt_nxt = 6'h00;
            bit_cnt_nxt  = 5'h00;
            rate_cnt_nxt = 8'h00;
            half_cnt_nxt = half_step - 7'h01;
            if (en && !role && tx_valid)
            begin
               tx_pop    = 1'b1;
               tx_sh_nxt = tx_head;
               ssel_nxt  = ~ssel_nxt;
               st_nxt    = ST_SHIFT;
            end
            else if (en && role && selected)
            begin
               tx_pop    = tx_valid;
               tx_sh_nxt = tx_valid ? tx_head : 16'h0000;
               st_nxt    = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            if (!en || (role && !selected))
               st_nxt = ST_IDLE;
            else if (role)
            begin
               if (rx_push)
               begin
                  // back-to-back slave frames under one select
                  bit_cnt_nxt = 5'h00;
                  tx_pop      = tx_valid;
                  tx_sh_nxt   = tx_valid ? tx_head : 16'h0000;
               end
            end
            else if (edge_evt)
            begin
               sclk_nxt     = ~sclk_r;
               edge_cnt_nxt = edge_cnt_r + 6'h01;
               if (edge_cnt_r + 6'h01 == {len, 1'b0})
                  st_nxt = ST_GAP;
            end
         end
         ST_GAP:
         begin
            // one half bit of released select between master frames
            ssel_nxt = (ffmt == FMT_SYNC_PULSE) ? 1'b0 : 1'b1;
            if (tog_tick || !en)
               st_nxt = ST_IDLE;
         end
         default:
            st_nxt = ST_IDLE;
      endcase
   end

   // shift engine registers
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r       <= ST_IDLE;
         half_cnt_r <= 7'h00;
         rate_cnt_r <= 8'h00;
         edge_cnt_r <= 6'h00;
         bit_cnt_r  <= 5'h00;
         tx_sh_r    <= 16'h0000;
         rx_sh_r    <= 16'h0000;
         sclk_r     <= 1'b0;
         ssel_r     <= 1'b1;
      end
      else
      begin
         st_r       <= st_nxt;
         half_cnt_r <= half_cnt_nxt;
         rate_cnt_r <= rate_cnt_nxt;
         edge_cnt_r <= edge_cnt_nxt;
         bit_cnt_r  <= bit_cnt_nxt;
         tx_sh_r    <= tx_sh_nxt;
         rx_sh_r    <= rx_sh_nxt;
         sclk_r     <= sclk_nxt;
         ssel_r     <= ssel_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pins: master drives clock, data out and select; slave only miso
   assign sclk_out = sclk_r;
   assign mosi_out = out_bit;
   assign ssel_out = ssel_r;
   assign miso_out = out_bit;
   assign sclk_oe  = en & ~role;
   assign mosi_oe  = en & ~role;
   assign ssel_oe  = en & ~role;
   assign miso_oe  = en & role & ~inhib & selected;

   ////////////////////////////////////////////////////////////////////////////////
   // register port: writes, fifo strobes and read mux
   assign tx_push = wr_en && (addr == `FIFO_DATA_OFS);
   assign rx_pop  = rd_en && (addr == `FIFO_DATA_OFS) && rx_valid;
   assign rdata   = rdata_r;

   always_comb
   begin
      fmt_nxt   = fmt_r;
      mode_nxt  = mode_r;
      pre_nxt   = pre_r;
      rdata_nxt = 32'h00000000;
      if (wr_en)
      begin
         case (addr)
            `FMT_CTRL_OFS:  fmt_nxt = wdata[15:0];
            `MODE_CTRL_OFS:
            begin
               mode_nxt[`LOOP_BIT]  = wdata[`LOOP_BIT];
               mode_nxt[`EN_BIT]    = wdata[`EN_BIT];
               mode_nxt[`INHIB_BIT] = wdata[`INHIB_BIT];
               if (!en)
                  mode_nxt[`ROLE_BIT] = wdata[`ROLE_BIT];
            end
            `PRESCALE_OFS:  pre_nxt = {wdata[7:1], 1'b0};
            default:        pre_nxt = pre_r;
         endcase
      end
      if (rd_en)
      begin
         case (addr)
            `FMT_CTRL_OFS:  rdata_nxt = {16'h0000, fmt_r};
            `MODE_CTRL_OFS: rdata_nxt = {28'h0000000, mode_r};
            `FIFO_DATA_OFS: rdata_nxt = {16'h0000, rx_valid ? rx_head : 16'h0000};
            `STATUS_OFS:    rdata_nxt = {27'h0000000, (st_r != ST_IDLE) || tx_valid,
                                         ~rx_room, rx_valid, tx_room, ~tx_valid};
            `PRESCALE_OFS:  rdata_nxt = {24'h000000, pre_r};
            default:        rdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fmt_r   <= `FMT_CTRL_RST;
         mode_r  <= `MODE_CTRL_RST;
         pre_r   <= `PRESCALE_RST;
         rdata_r <= 32'h00000000;
      end
      else
      begin
         fmt_r   <= fmt_nxt;
         mode_r  <= mode_nxt;
         pre_r   <= pre_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks; helper counts cycles between master clock toggles
   logic [15:0] since_tog_r;
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         since_tog_r <= 16'h0000;
      else
         since_tog_r <= (edge_evt || st_r != ST_SHIFT) ? 16'h0000 : since_tog_r + 16'h0001;
   end

   sequence s_write_idle;
      wr_en && addr == `FIFO_DATA_OFS && !tx_valid && st_r == ST_IDLE && en && !role;
   endsequence
   sequence s_frame_start;
      ##2 (st_r == ST_SHIFT && !ssel_r);
   endsequence

   property p_role_locked;
      @(posedge clock) disable iff (!rst_b)
      wr_en && addr == `MODE_CTRL_OFS && en |=> role == $past(role);
   endproperty
   a_role_locked: assert property (p_role_locked) else $error("role changed while enabled");
   property p_fmt_write;
      @(posedge clock) disable iff (!rst_b)
      wr_en && addr == `FMT_CTRL_OFS |=> ffmt == frame_format_t'($past(wdata[5:4]));
   endproperty
   a_fmt_write: assert property (p_fmt_write) else $error("format field not stored");
   property p_idle_clock;
      @(posedge clock) disable iff (!rst_b)
      st_r == ST_IDLE && $past(st_r) == ST_IDLE && $stable(fmt_r) |-> sclk_out == idle_lvl;
   endproperty
   a_idle_clock: assert property (p_idle_clock) else $error("idle clock level wrong");
   property p_rate;
      @(posedge clock) disable iff (!rst_b)
      edge_evt && !role && edge_cnt_r != 6'h00 && $stable(fmt_r) && $stable(pre_r)
      |-> since_tog_r + 16'h0001 == 16'(half_step * ({1'b0, fmt_r[15:8]} + 9'h001));
   endproperty
   a_rate: assert property (p_rate) else $error("half bit period wrong");
   property p_loop;
      @(posedge clock) disable iff (!rst_b)
      sample && loop |=> rx_sh_r[0] == $past(out_bit);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback bit not captured");
   property p_disabled;
      @(posedge clock) disable iff (!rst_b)
      !en |-> !sclk_oe && !mosi_oe && !miso_oe && !ssel_oe;
   endproperty
   a_disabled: assert property (p_disabled) else $error("pin driven while disabled");
   property p_inhibit;
      @(posedge clock) disable iff (!rst_b)
      role && inhib |-> !miso_oe;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("miso driven while inhibited");
   property p_tx_start;
      @(posedge clock) disable iff (!rst_b)
      s_write_idle ##0 (ffmt != FMT_SYNC_PULSE) |-> s_frame_start;
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("frame did not start at once");
   property p_rx_read;
      @(posedge clock) disable iff (!rst_b)
      rx_pop |=> rdata_r == {16'h0000, $past(rx_head)};
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("read data not oldest frame");
   property p_room;
      @(posedge clock) disable iff (!rst_b)
      rd_en && addr == `STATUS_OFS |=> rdata_r[`ST_TX_ROOM] == $past(tx_room);
   endproperty
   a_room: assert property (p_room) else $error("room flag wrong");
   property p_prescale_lsb;
      @(posedge clock) disable iff (!rst_b)
      rd_en && addr == `PRESCALE_OFS |=> rdata_r[0] == 1'b0;
   endproperty
   a_prescale_lsb: assert property (p_prescale_lsb) else $error("prescale low bit set");
endmodule

// >>> sim/spi_slave_model.sv
// behavioural serial slave device, mode 0, eight-bit frames
`timescale 1ns/1ps
module spi_slave_model (
   // serial lines from the master
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       ssel_b,
   // reply word and captured word
   input  wire logic [7:0] reply,
   output logic            miso,
   output logic [7:0]      got
);
   logic [7:0] tx_sh;
   initial
   begin
      miso = 1'b0;
      got = 8'h00;
   end
   // load reply when selected, msb leads
   always @(negedge ssel_b)
   begin
      tx_sh = reply;
      miso = reply[7];
   end
   // capture on rising edge, change on falling edge
   always @(posedge sclk) if (!ssel_b) got = {got[6:0], mosi};
   always @(negedge sclk)
      if (!ssel_b)
      begin
         tx_sh = {tx_sh[6:0], 1'b0};
         miso = tx_sh[7];
      end
   // released line must not look like held data
   always @(posedge ssel_b) miso = ~miso;
endmodule

// >>> sim/tb.sv
// self-checking bench for the serial port controller
`timescale 1ns/1ps
`include "serial_port_defines.svh"
module tb;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [31:0] rdata;
   logic        sclk_in = 1'b0;
   logic        ssel_in = 1'b1;
   logic        mosi_in = 1'b0;
   logic        sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, ssel_out, ssel_oe, miso_p;
   logic [7:0]  got;
   int          num_errors = 0;
   int          checks = 0;

   always #4 clock = ~clock;

   serial_port_ctrl DUT (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
      .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_p), .miso_out(miso_out),
      .miso_oe(miso_oe), .ssel_in(ssel_in), .ssel_out(ssel_out), .ssel_oe(ssel_oe));
   spi_slave_model peer (.sclk(sclk_out), .mosi(mosi_out), .ssel_b(ssel_out), .reply(8'h3c),
      .miso(miso_p), .got(got));

   ////////////////////////////////////////////////////////////////////////////
   // bus cycles and comparison
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clock);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(n, e, d);
   endtask
   // poll until a received frame waits, bounded
   task automatic wait_rx;
      logic [31:0] d;
      int i;
      d = 32'h0;
      for (i = 0; i < 300 && d[`ST_RX_ENTRY] !== 1'b1; i++) rd(`STATUS_OFS, d);
      chk("rx entry", 32'h1, {31'h0, d[`ST_RX_ENTRY]});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      rdchk("status", `STATUS_OFS, 32'h3);
      rdchk("mode", `MODE_CTRL_OFS, 32'h0);
      rdchk("format", `FMT_CTRL_OFS, 32'h0);
      rdchk("empty data", `FIFO_DATA_OFS, 32'h0);
      rdchk("unmapped", 32'h40040020, 32'h0);
      wr(`PRESCALE_OFS, 32'h5);
      rdchk("prescale", `PRESCALE_OFS, 32'h4);
   endtask
   task automatic t_loop_formats;
      int f;
      wr(`PRESCALE_OFS, 32'h2);
      // last pass: spi with idle-high clock and second-edge capture
      for (f = 0; f < 4; f++)
      begin
         wr(`MODE_CTRL_OFS, 32'h1);
         wr(`FMT_CTRL_OFS, (f == 3) ? 32'hc3 : ((f << `FMT_LSB) | 32'h3));
         wr(`MODE_CTRL_OFS, 32'h3);
         wr(`FIFO_DATA_OFS, 32'h9 + f);
         wait_rx();
         rdchk("loop word", `FIFO_DATA_OFS, 32'h9 + f);
      end
      wr(`MODE_CTRL_OFS, 32'h0);
   endtask
   task automatic t_master;
      int n;
      wr(`PRESCALE_OFS, 32'h4);
      wr(`FMT_CTRL_OFS, 32'h0307);
      wr(`MODE_CTRL_OFS, 32'h2);
      // let the enable write settle before looking at the pins
      #1;
      chk("idle clock", 32'h0, {31'h0, sclk_out});
      chk("master oe", 32'h7, {29'h0, sclk_oe, mosi_oe, ssel_oe});
      wr(`FIFO_DATA_OFS, 32'ha5);
      n = 0;
      while (sclk_out !== 1'b1 && n < 100)
      begin
         @(posedge clock) #1;
         n++;
      end
      n = 0;
      while (sclk_out === 1'b1 && n < 100)
      begin
         @(posedge clock) #1;
         n++;
      end
      chk("half bit", 32'd8, n);
      wait_rx();
      rdchk("rx word", `FIFO_DATA_OFS, 32'h3c);
      chk("peer word", 32'ha5, {24'h0, got});
      wr(`MODE_CTRL_OFS, 32'h0);
      wr(`FMT_CTRL_OFS, 32'h0347);
      wr(`MODE_CTRL_OFS, 32'h2);
      repeat (3) @(posedge clock);
      chk("idle high", 32'h1, {31'h0, sclk_out});
      wr(`MODE_CTRL_OFS, 32'h0);
   endtask
   // one eight-bit frame from an outside master, slow clock, mode 0
   task automatic t_slave_frame;
      logic [7:0] pat;
      logic [7:0] seen;
      int         i;
      pat = 8'h5a;
      seen = 8'h00;
      wr(`FMT_CTRL_OFS, 32'h0307);
      wr(`MODE_CTRL_OFS, 32'h4);
      wr(`FIFO_DATA_OFS, 32'h96);
      wr(`MODE_CTRL_OFS, 32'h6);
      ssel_in <= 1'b0;
      repeat (4) @(posedge clock);
      for (i = 7; i >= 0; i--)
      begin
         mosi_in <= pat[i];
         repeat (8) @(posedge clock);
         seen = {seen[6:0], miso_out};
         sclk_in <= 1'b1;
         repeat (8) @(posedge clock);
         sclk_in <= 1'b0;
      end
      repeat (8) @(posedge clock);
      ssel_in <= 1'b1;
      chk("slave miso", 32'h96, {24'h0, seen});
      wait_rx();
      rdchk("slave rx", `FIFO_DATA_OFS, 32'h5a);
      wr(`MODE_CTRL_OFS, 32'h0);
   endtask
   task automatic t_slave;
      wr(`MODE_CTRL_OFS, 32'h4);
      wr(`MODE_CTRL_OFS, 32'h6);
      ssel_in <= 1'b0;
      repeat (4) @(posedge clock);
      chk("slave oe", 32'h4, {29'h0, miso_oe, sclk_oe, mosi_oe});
      wr(`MODE_CTRL_OFS, 32'h0);
      rdchk("role kept", `MODE_CTRL_OFS, 32'h4);
      wr(`MODE_CTRL_OFS, 32'he);
      repeat (4) @(posedge clock);
      chk("inhibit", 32'h0, {31'h0, miso_oe});
      ssel_in <= 1'b1;
      wr(`MODE_CTRL_OFS, 32'h4);
      wr(`MODE_CTRL_OFS, 32'h0);
      rdchk("role clear", `MODE_CTRL_OFS, 32'h0);
   endtask
   task automatic t_fill;
      int i;
      wr(`MODE_CTRL_OFS, 32'h2);
      for (i = 0; i < 8; i++) wr(`FIFO_DATA_OFS, 32'h11 * i);
      rdchk("room left", `STATUS_OFS, 32'h12);
      wr(`FIFO_DATA_OFS, 32'h77);
      rdchk("full", `STATUS_OFS, 32'h10);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // verdict, watchdog and main sequence
   task automatic stop_test;
      if (num_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #400000;
      num_errors++;
      stop_test();
   end
   initial
   begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      t_reset();
      t_loop_formats();
      t_master();
      t_slave_frame();
      t_slave();
      t_fill();
      stop_test();
   end
endmodule
